// [bench/pci_host_model.sv]
`timescale 1ns/1ps
// Arbiter side of the request and grant pair; grant after 1 or 4 clocks
module pci_host_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reqOutN,
  input wire logic reqOe,
  input wire logic slowGrant,
  output logic gntInN
);
  logic reqLine;
  logic [1:0] waitCnt;
  ////////////////////////////////////////////////////////////////////////////
  // Pull-up on the request wire, so a floated request reads as idle
  assign reqLine = reqOe ? reqOutN : 1'b1;
  // Grant only while a request is seen; withdrawn request drops the grant
  always_ff @(posedge core_clk) begin
    if (!nrst || reqLine) begin
      gntInN <= 1'b1;
      waitCnt <= 2'h0;
    end else if (waitCnt == (slowGrant ? 2'h3 : 2'h0)) begin
      gntInN <= 1'b0;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : pci_host_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import psc_pkg::*;
  logic core_clk, nrst, wbCyc, wbStb, wbWe, wbAck, slowGrant;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, v;
  logic supply_good_in, reqOutN, reqOe, gntInN, intaOutN, intaOe, m66En;
  logic serrOutN, serrOe, perrOutN, perrOe, pmeOutN, pmeOe;
  logic aux_supply_present, port_disable_n, masterNeed, coreIntReq;
  logic addrParErr, dataParErr, specialCycle, wakeEvent, nvmLoad, masterGo;
  logic busSpeed66, d3coldSupport, portDisabled, inReset;
  sdp_t soft_defined_pins_in, soft_defined_pins_out, soft_defined_pins_oe;
  sdp_t nvmSdpDir, nvmSdpOut;
  logic [31:0] expQ[$];
  int num_errors, checks, seed, n;
  ////////////////////////////////////////////////////////////////////////////
  pci_sideband_control i_pci_sideband_control (.core_clk, .nrst, .wbCyc,
    .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck, .supply_good_in,
    .reqOutN, .reqOe, .gntInN, .intaOutN, .intaOe, .m66En, .serrOutN,
    .serrOe, .perrOutN, .perrOe, .pmeOutN, .pmeOe, .aux_supply_present,
    .port_disable_n, .soft_defined_pins_in, .soft_defined_pins_out,
    .soft_defined_pins_oe, .masterNeed, .coreIntReq, .addrParErr,
    .dataParErr, .specialCycle, .wakeEvent, .nvmLoad, .nvmSdpDir, .nvmSdpOut,
    .masterGo, .busSpeed66, .d3coldSupport, .portDisabled, .inReset);
  pci_host_model i_pci_host_model (.core_clk, .nrst, .reqOutN, .reqOe,
    .slowGrant, .gntInN);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the watchdog span is about 27 times the test length
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Read data is judged where the ack shows, against the oldest note
  always @(posedge core_clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      if (expQ.size() == 0) chk(32'h1, 32'h0);
      else chk(wbDatR, expQ.pop_front());
    end
  end
  // Classic single cycle; waits for ack with no assumed latency
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= a;
    wbDatW <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 40);
    if (k >= 40) chk(32'h1, 32'h0);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // Bus reset with the strap value; outputs checked while reset is held
  task automatic rst_pulse(input logic pd);
    @(posedge core_clk);
    port_disable_n <= pd;
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk({reqOe, intaOe, serrOe, perrOe, wbAck}, 32'h0);
    chk(inReset, 1'b1);
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rst_pulse
  // Parity error run of len phases; walk checks drive, park and float
  task automatic perr_case(input int len, input logic sc);
    @(posedge core_clk);
    dataParErr <= 1'b1;
    specialCycle <= sc;
    repeat (len) @(posedge core_clk);
    dataParErr <= 1'b0;
    for (int k = len; k < len + 4; k++) begin
      @(posedge core_clk);
      #1 chk(perrOe, !sc && k <= len + 1);
      if (perrOe === 1'b1) chk(perrOutN, k == len + 1);
    end
    @(posedge core_clk);
    specialCycle <= 1'b0;
  endtask : perr_case
  task automatic close_out();
    $display("counts: checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 64;
    {nrst, supply_good_in, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
    {m66En, aux_supply_present, masterNeed, coreIntReq, addrParErr} = '0;
    {dataParErr, specialCycle, wakeEvent, nvmLoad, slowGrant} = '0;
    port_disable_n = 1'b1;
    soft_defined_pins_in = 4'h0;
    nvmSdpDir = 4'h0;
    nvmSdpOut = 4'h0;
    wbSel = 4'hf;
    repeat (2) @(posedge core_clk);
    supply_good_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(soft_defined_pins_oe, 4'h0);
    rd(8'h0c, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    m66En <= 1'b1;
    aux_supply_present <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk({busSpeed66, d3coldSupport}, 2'h3);
    rd(8'h04, 32'h6);
    for (int g = 0; g < 2; g++) begin
      slowGrant <= g[0];
      masterNeed <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (masterGo !== 1'b1 && n < 20);
      chk({reqOe, reqOutN}, 2'h2);
      chk(masterGo, 1'b1);
      masterNeed <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk(reqOutN, 1'b1);
      @(posedge core_clk);
    end
    wb(1'b1, 8'h00, 32'h3);
    rd(8'h00, 32'h3);
    chk({reqOe, reqOutN}, 2'h2);
    wb(1'b1, 8'h00, 32'h0);
    $display("test request done");
    addrParErr <= 1'b1;
    @(posedge core_clk);
    addrParErr <= 1'b0;
    #1 chk({serrOe, serrOutN}, 2'h2);
    @(posedge core_clk);
    #1 chk(serrOe, 1'b0);
    perr_case(1, 1'b0);
    perr_case(2, 1'b0);
    perr_case(1, 1'b1);
    $display("test parity done");
    coreIntReq <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1 chk({intaOe, intaOutN}, 2'h2);
    @(posedge core_clk);
    coreIntReq <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(intaOe, 1'b0);
    $display("test interrupt done");
    @(posedge core_clk);
    wakeEvent <= 1'b1;
    @(posedge core_clk);
    wakeEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(pmeOe, 1'b0);
    wb(1'b1, 8'h08, 32'h1);
    @(posedge core_clk);
    wakeEvent <= 1'b1;
    @(posedge core_clk);
    wakeEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({pmeOe, pmeOutN}, 2'h2);
    rst_pulse(1'b1);
    chk(pmeOe, 1'b1);
    wb(1'b1, 8'h08, 32'h2);
    repeat (2) @(posedge core_clk);
    #1 chk(pmeOe, 1'b0);
    // Same wake path, now enabled through the PCI enable bit
    wb(1'b1, 8'h00, 32'h2);
    wakeEvent <= 1'b1;
    @(posedge core_clk);
    wakeEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({pmeOe, pmeOutN}, 2'h2);
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b1, 8'h00, 32'h0);
    $display("test wake done");
    v = $random(seed) & 32'h3ff;
    wb(1'b1, 8'h0c, v);
    rd(8'h0c, v);
    chk({soft_defined_pins_oe, soft_defined_pins_out}, v[7:0]);
    rst_pulse(1'b1);
    rd(8'h0c, 32'h0);
    nvmSdpDir <= 4'h1;
    nvmSdpOut <= 4'h1;
    nvmLoad <= 1'b1;
    @(posedge core_clk);
    nvmLoad <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({soft_defined_pins_oe, soft_defined_pins_out}, 8'h11);
    wb(1'b1, 8'h0c, 32'h300);
    soft_defined_pins_in <= 4'hc;
    repeat (5) @(posedge core_clk);
    rd(8'h10, 32'h3);
    chk(intaOe, 1'b1);
    wb(1'b1, 8'h10, 32'h3);
    repeat (2) @(posedge core_clk);
    #1 chk(intaOe, 1'b0);
    $display("test soft pins done");
    rst_pulse(1'b0);
    chk(portDisabled, 1'b1);
    masterNeed <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk(reqOe & ~reqOutN, 1'b0);
    @(posedge core_clk);
    masterNeed <= 1'b0;
    rst_pulse(1'b1);
    chk(portDisabled, 1'b0);
    supply_good_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk({inReset, reqOe, intaOe, perrOe}, 4'h8);
    $display("test supply done");
    close_out();
  end
endmodule : tb_top

// [logic/pci_sideband_control.sv]
`timescale 1ns/1ps
`include "psc_defines.svh"

// Notes on behaviour
// - Drive bus request low when mastering wanted
// - Interrupt line held low while request pending
// - Bus inputs sampled on rising clock edge
// - Bus reset floats outputs except wake line
// - Wake event context survives bus reset
// - Internal state restarts at reset release
// - Supply-good low holds reset, floats bus
// - Wake line pulled low only when enabled
// - Auxiliary supply present allows D3cold support
// - Port-disable strap sampled at reset release
// - Soft pins default inputs, upper two interrupt
// - Sustained line parked high before release
module pci_sideband_control (
  input wire logic core_clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Pins
  input wire logic supply_good_in,
  output logic reqOutN,
  output logic reqOe,
  input wire logic gntInN,
  output logic intaOutN,
  output logic intaOe,
  input wire logic m66En,
  output logic serrOutN,
  output logic serrOe,
  output logic perrOutN,
  output logic perrOe,
  output logic pmeOutN,
  output logic pmeOe,
  input wire logic aux_supply_present,
  input wire logic port_disable_n,
  input wire psc_pkg::sdp_t soft_defined_pins_in,
  output psc_pkg::sdp_t soft_defined_pins_out,
  output psc_pkg::sdp_t soft_defined_pins_oe,
  // Core side, same clock
  input wire logic masterNeed,
  input wire logic coreIntReq,
  input wire logic addrParErr,
  input wire logic dataParErr,
  input wire logic specialCycle,
  input wire logic wakeEvent,
  input wire logic nvmLoad,
  input wire psc_pkg::sdp_t nvmSdpDir,
  input wire psc_pkg::sdp_t nvmSdpOut,
  output logic masterGo,
  output logic busSpeed66,
  output logic d3coldSupport,
  output logic portDisabled,
  output logic inReset
);
  import psc_pkg::*;

  logic [`PSC_SYNC_W-1:0] syncIn;
  logic [`PSC_SYNC_W-1:0] syncOut;
  logic gntS, m66S, auxS, pdisS, pgoodS;
  sdp_t sdpS;
  logic rstAll, rstAllQ_q, relEdge;
  logic ctrlReq_q, pmeEn_q, wakeMgmt_q, pmeStat_q;
  logic reqOut_q, serr_q, want, wbWr, wbRd, pending;
  sdp_t sdpDir_q, sdpOut_q, sdpPrev_q;
  gpi_t gpiEn_q, intCause_q, gpiRise;
  logic perrPipe_q;
  perr_state_e perr_q;

  // Address decode shared by read and write paths
  function automatic logic regHit(input logic [7:0] adr,
                                  input logic [7:0] off);
    regHit = (adr == off);
  endfunction : regHit

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling on the rising edge through two flops
  assign syncIn = {soft_defined_pins_in, supply_good_in, port_disable_n,
                   aux_supply_present, m66En, gntInN};
  pin_sync #(.W(`PSC_SYNC_W)) u_sync (
    .core_clk(core_clk),
    .pinIn(syncIn),
    .pinSync(syncOut)
  );
  assign gntS = syncOut[0];
  assign m66S = syncOut[1];
  assign auxS = syncOut[2];
  assign pdisS = syncOut[3];
  assign pgoodS = syncOut[4];
  assign sdpS = syncOut[8:5];

  ////////////////////////////////////////////////////////////////////////
  // Either reset source holds the block in reset
  assign rstAll = !nrst || !pgoodS;
  assign inReset = rstAll;
  assign relEdge = !rstAll && rstAllQ_q;

  // Remembers last reset level to find the release edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rstAllQ_q <= 1'b1;
    end else begin
      rstAllQ_q <= rstAll;
    end
  end

  // Strap caught at release; low means port off, so no bus request
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      portDisabled <= 1'b0;
    end else if (relEdge) begin
      portDisabled <= !pdisS;
    end
  end

  // Speed and aux supply follow their sampled pins
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      busSpeed66 <= 1'b0;
      d3coldSupport <= 1'b0;
    end else begin
      busSpeed66 <= m66S;
      d3coldSupport <= auxS;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone: one wait state, writes land on the acked edge
  assign wbWr = wbCyc && wbStb && wbWe && wbAck;
  assign wbRd = wbCyc && wbStb && !wbWe && !wbAck;

  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbCyc && wbStb && !wbAck;
    end
  end

  // Read mux; unmapped offsets read zero and still ack
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      wbDatR <= 32'h0;
    end else if (wbRd) begin
      wbDatR <= 32'h0;
      if (regHit(wbAdr, `PSC_ADR_CTRL)) begin
        wbDatR[`PSC_CTRL_REQ] <= ctrlReq_q;
        wbDatR[`PSC_CTRL_PMEEN] <= pmeEn_q;
      end
      if (regHit(wbAdr, `PSC_ADR_STAT)) begin
        wbDatR[`PSC_ST_GNT] <= !gntS;
        wbDatR[`PSC_ST_M66] <= busSpeed66;
        wbDatR[`PSC_ST_AUX] <= d3coldSupport;
        wbDatR[`PSC_ST_PDIS] <= portDisabled;
        wbDatR[`PSC_ST_SERR] <= serr_q;
        wbDatR[`PSC_ST_PERR] <= perr_q != PERR_IDLE;
        wbDatR[`PSC_ST_SDP_HI:`PSC_ST_SDP_LO] <= sdpS;
      end
      if (regHit(wbAdr, `PSC_ADR_WAKE)) begin
        wbDatR[`PSC_WAKE_MGMT] <= wakeMgmt_q;
        wbDatR[`PSC_WAKE_STAT] <= pmeStat_q;
      end
      if (regHit(wbAdr, `PSC_ADR_SDP)) begin
        wbDatR[`PSC_SDP_OUT_HI:`PSC_SDP_OUT_LO] <= sdpOut_q;
        wbDatR[`PSC_SDP_DIR_HI:`PSC_SDP_DIR_LO] <= sdpDir_q;
        wbDatR[`PSC_SDP_GPI_HI:`PSC_SDP_GPI_LO] <= gpiEn_q;
      end
      if (regHit(wbAdr, `PSC_ADR_INT)) begin
        wbDatR[`PSC_INT_HI:`PSC_INT_LO] <= intCause_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus request; held off when the port is strapped off
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      ctrlReq_q <= 1'b0;
    end else if (wbWr && wbSel[0] && regHit(wbAdr, `PSC_ADR_CTRL)) begin
      ctrlReq_q <= wbDatW[`PSC_CTRL_REQ];
    end
  end

  assign want = (ctrlReq_q || masterNeed) && !portDisabled;

  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      reqOut_q <= 1'b1;
    end else begin
      reqOut_q <= !want;
    end
  end
  assign reqOutN = reqOut_q;
  assign reqOe = !rstAll;
  // Master may start only once the arbiter grants
  assign masterGo = !rstAll && !reqOut_q && !gntS && want;

  ////////////////////////////////////////////////////////////////////////
  // Wake context is cleared only by supply-good, not by bus reset
  always_ff @(posedge core_clk) begin
    if (!pgoodS) begin
      pmeEn_q <= 1'b0;
      wakeMgmt_q <= 1'b0;
      pmeStat_q <= 1'b0;
    end else begin
      if (nrst && wbWr && wbSel[0] && regHit(wbAdr, `PSC_ADR_CTRL)) begin
        pmeEn_q <= wbDatW[`PSC_CTRL_PMEEN];
      end
      if (nrst && wbWr && wbSel[0] && regHit(wbAdr, `PSC_ADR_WAKE)) begin
        wakeMgmt_q <= wbDatW[`PSC_WAKE_MGMT];
      end
      // Set wins over a write-one clear in the same cycle
      if (wakeEvent && (pmeEn_q || wakeMgmt_q)) begin
        pmeStat_q <= 1'b1;
      end else if (nrst && wbWr && wbSel[0] &&
                   regHit(wbAdr, `PSC_ADR_WAKE) &&
                   wbDatW[`PSC_WAKE_STAT]) begin
        pmeStat_q <= 1'b0;
      end
    end
  end
  assign pmeOutN = 1'b0;
  // Open drain; still active during bus reset
  assign pmeOe = pgoodS && pmeStat_q && (pmeEn_q || wakeMgmt_q);

  ////////////////////////////////////////////////////////////////////////
  // System error: one-clock open-drain pulse
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      serr_q <= 1'b0;
    end else begin
      serr_q <= addrParErr;
    end
  end
  assign serrOutN = 1'b0;
  assign serrOe = serr_q && !rstAll;

  ////////////////////////////////////////////////////////////////////////
  // Parity error: detect, one stage, then drive in the state machine
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      perrPipe_q <= 1'b0;
    end else begin
      perrPipe_q <= dataParErr && !specialCycle;
    end
  end

  // Park high one clock before floating so the pullup is not raced
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      perr_q <= PERR_IDLE;
    end else begin
      unique case (perr_q)
        PERR_IDLE: begin
          if (perrPipe_q) begin
            perr_q <= PERR_LOW;
          end
        end
        PERR_LOW: begin
          if (!perrPipe_q) begin
            perr_q <= PERR_PARK;
          end
        end
        PERR_PARK: begin
          perr_q <= perrPipe_q ? PERR_LOW : PERR_IDLE;
        end
        default: begin
          perr_q <= PERR_IDLE;
        end
      endcase
    end
  end
  // Gated by reset too: the state only clears on the first reset edge
  assign perrOe = (perr_q != PERR_IDLE) && !rstAll;
  assign perrOutN = perr_q == PERR_PARK;

  ////////////////////////////////////////////////////////////////////////
  // Soft pins: inputs at reset, loadable from nonvolatile config
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      sdpDir_q <= `PSC_SDP_DIR_RST;
      sdpOut_q <= `PSC_SDP_OUT_RST;
      gpiEn_q <= `PSC_GPI_RST;
    end else if (nvmLoad) begin
      sdpDir_q <= nvmSdpDir;
      sdpOut_q <= nvmSdpOut;
    end else if (wbWr && regHit(wbAdr, `PSC_ADR_SDP)) begin
      if (wbSel[0]) begin
        sdpOut_q <= wbDatW[`PSC_SDP_OUT_HI:`PSC_SDP_OUT_LO];
        sdpDir_q <= wbDatW[`PSC_SDP_DIR_HI:`PSC_SDP_DIR_LO];
      end
      if (wbSel[1]) begin
        gpiEn_q <= wbDatW[`PSC_SDP_GPI_HI:`PSC_SDP_GPI_LO];
      end
    end
  end
  assign soft_defined_pins_out = sdpOut_q;
  assign soft_defined_pins_oe = rstAll ? `PSC_SDP_DIR_RST : sdpDir_q;

  // Rising edges on the upper two pins, only when they are inputs
  always_ff @(posedge core_clk) begin
    sdpPrev_q <= sdpS;
  end
  assign gpiRise = gpiEn_q
    & ~sdpDir_q[`PSC_GPI_PIN_HI:`PSC_GPI_PIN_LO]
    & sdpS[`PSC_GPI_PIN_HI:`PSC_GPI_PIN_LO]
    & ~sdpPrev_q[`PSC_GPI_PIN_HI:`PSC_GPI_PIN_LO];

  // Sticky causes; a new edge beats a write-one clear
  always_ff @(posedge core_clk) begin
    if (rstAll) begin
      intCause_q <= `PSC_GPI_RST;
    end else if (wbWr && wbSel[0] && regHit(wbAdr, `PSC_ADR_INT)) begin
      intCause_q <= (intCause_q &
        ~wbDatW[`PSC_INT_HI:`PSC_INT_LO]) | gpiRise;
    end else begin
      intCause_q <= intCause_q | gpiRise;
    end
  end

  // Level interrupt, held low until every cause is gone
  assign pending = (|intCause_q) || coreIntReq;
  assign intaOutN = 1'b0;
  assign intaOe = pending && !rstAll;

  ////////////////////////////////////////////////////////////////////////
  property p_req;
    @(posedge core_clk) disable iff (rstAll)
    want ##1 want |-> !reqOutN && reqOe;
  endproperty
  a_req: assert property (p_req) else $error("request not driven");

  property p_inta;
    @(posedge core_clk) disable iff (rstAll)
    $rose(|intCause_q) |-> intaOe ##1 (intaOe || $past(wbWr));
  endproperty
  a_inta: assert property (p_inta) else $error("interrupt not held");

  property p_float;
    @(posedge core_clk) rstAll |-> !reqOe && !intaOe && !serrOe
      && !perrOe && soft_defined_pins_oe == `PSC_SDP_DIR_RST;
  endproperty
  a_float: assert property (p_float) else $error("pin driven in reset");

  property p_ctx;
    @(posedge core_clk) !nrst && pgoodS && pmeStat_q |=> pmeStat_q;
  endproperty
  a_ctx: assert property (p_ctx) else $error("wake context lost");

  property p_serr;
    @(posedge core_clk) disable iff (rstAll)
    addrParErr ##1 !addrParErr |-> serrOe ##1 !serrOe;
  endproperty
  a_serr: assert property (p_serr) else $error("serr not one clock");

  property p_perr;
    @(posedge core_clk) disable iff (rstAll)
    dataParErr && !specialCycle |-> ##2 (perrOe && !perrOutN);
  endproperty
  a_perr: assert property (p_perr) else $error("perr late");

  property p_park;
    @(posedge core_clk) disable iff (rstAll)
    perr_q == PERR_LOW ##1 perr_q != PERR_LOW
      |-> perrOe && perrOutN;
  endproperty
  a_park: assert property (p_park) else $error("perr not parked");

  property p_pme;
    @(posedge core_clk) disable iff (!pgoodS)
    !pmeEn_q && !wakeMgmt_q && !pmeStat_q |=> !pmeOe;
  endproperty
  a_pme: assert property (p_pme) else $error("wake while disabled");

  property p_strap;
    @(posedge core_clk) relEdge |=> portDisabled == !$past(pdisS);
  endproperty
  a_strap: assert property (p_strap) else $error("strap missed");

  c_serr: cover property (@(posedge core_clk) serrOe);
  c_park: cover property (@(posedge core_clk) perr_q == PERR_PARK);
  c_pme: cover property (@(posedge core_clk) pmeOe && !nrst);
  c_grant: cover property (@(posedge core_clk) masterGo);
endmodule : pci_sideband_control

// [logic/pin_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser bank; no reset so supply-good keeps its path
module pin_sync #(
  parameter int W = 9
) (
  input wire logic core_clk,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] meta_q;

  ////////////////////////////////////////////////////////////////////////
  // Only the second flop is visible to the block
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        meta_q[i] <= pinIn[i];
        pinSync[i] <= meta_q[i];
      end
    end
  endgenerate
endmodule : pin_sync

// [logic/psc_defines.svh]
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// Register byte offsets on the Wishbone slave
`define PSC_ADR_CTRL 8'h00
`define PSC_ADR_STAT 8'h04
`define PSC_ADR_WAKE 8'h08
`define PSC_ADR_SDP 8'h0c
`define PSC_ADR_INT 8'h10
// Control register fields
`define PSC_CTRL_REQ 0
`define PSC_CTRL_PMEEN 1
// Wake control register fields
`define PSC_WAKE_MGMT 0
`define PSC_WAKE_STAT 1
// Status register fields
`define PSC_ST_GNT 0
`define PSC_ST_M66 1
`define PSC_ST_AUX 2
`define PSC_ST_PDIS 3
`define PSC_ST_SERR 4
`define PSC_ST_PERR 5
`define PSC_ST_SDP_LO 8
`define PSC_ST_SDP_HI 11
// Soft pin register fields
`define PSC_SDP_OUT_LO 0
`define PSC_SDP_OUT_HI 3
`define PSC_SDP_DIR_LO 4
`define PSC_SDP_DIR_HI 7
`define PSC_SDP_GPI_LO 8
`define PSC_SDP_GPI_HI 9
// Interrupt cause field
`define PSC_INT_LO 0
`define PSC_INT_HI 1
// Reset values
`define PSC_SDP_DIR_RST 4'h0
`define PSC_SDP_OUT_RST 4'h0
`define PSC_GPI_RST 2'h0
// Soft pins that may raise interrupts
`define PSC_GPI_PIN_LO 2
`define PSC_GPI_PIN_HI 3
// Synchroniser bank slots
`define PSC_SYNC_W 9
`endif

// [logic/psc_pkg.sv]
package psc_pkg;
  typedef logic [3:0] sdp_t;
  typedef logic [1:0] gpi_t;
  // Gray along idle -> drive low -> drive high; drive high -> idle flips both bits
  typedef enum logic [1:0] {
    PERR_IDLE = 2'b00,
    PERR_LOW = 2'b01,
    PERR_PARK = 2'b11
  } perr_state_e;
endpackage : psc_pkg
